// ==== bench/block_ram_fifo_and_ports_tb.sv ====
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin err_total++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end

module block_ram_fifo_and_ports_tb
    import brf_pkg::*;
;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic global_reset_n = 1'b1;
    logic port_a_latch_reset = 1'b0;
    logic port_b_latch_reset = 1'b0;
    logic fifo_mode = 1'b0;
    logic [3:0] port_a_addr = '0;
    logic [7:0] port_a_wdata = '0;
    logic port_a_ce = 1'b0;
    logic port_a_we = 1'b0;
    wmode_e port_a_wmode = WM_NORMAL;
    logic [3:0] port_b_addr = '0;
    logic [7:0] port_b_wdata = '0;
    logic port_b_ce = 1'b0;
    logic port_b_we = 1'b0;
    wmode_e port_b_wmode = WM_NORMAL;
    logic wr_clock, wr_clock_enable, wr_request, rd_clock, rd_clock_enable, rd_request;
    logic [7:0] wr_data;
    logic fifo_reset = 1'b0;
    logic read_pointer_reset_in = 1'b0;
    logic [3:0] full_level = 4'h4;
    logic [3:0] near_full_level = 4'h3;
    logic [3:0] near_empty_level = 4'h1;
    logic [7:0] port_a_rdata, port_b_rdata, got;
    logic full_flag, near_full_flag, near_empty_flag, empty_flag;
    int err_total = 0;
    int num_checks = 0;

    always #5 clk_sys = ~clk_sys;

    block_ram_fifo_and_ports #(.ADDR_W(4), .DATA_W(8), .LATCH_ASYNC_RST(1'b0))
    block_ram_fifo_and_ports_inst (
        .clk_sys(clk_sys), .arst_n(arst_n), .global_reset_n(global_reset_n),
        .port_a_latch_reset(port_a_latch_reset), .port_b_latch_reset(port_b_latch_reset),
        .fifo_mode(fifo_mode), .port_a_addr(port_a_addr), .port_a_wdata(port_a_wdata),
        .port_a_ce(port_a_ce), .port_a_we(port_a_we), .port_a_wmode(port_a_wmode),
        .port_b_addr(port_b_addr), .port_b_wdata(port_b_wdata), .port_b_ce(port_b_ce),
        .port_b_we(port_b_we), .port_b_wmode(port_b_wmode), .wr_clock(wr_clock),
        .wr_clock_enable(wr_clock_enable), .wr_request(wr_request), .wr_data(wr_data),
        .rd_clock(rd_clock), .rd_clock_enable(rd_clock_enable), .rd_request(rd_request),
        .fifo_reset(fifo_reset), .read_pointer_reset_in(read_pointer_reset_in),
        .full_level(full_level), .near_full_level(near_full_level),
        .near_empty_level(near_empty_level), .port_a_rdata(port_a_rdata),
        .port_b_rdata(port_b_rdata), .full_flag(full_flag), .near_full_flag(near_full_flag),
        .near_empty_flag(near_empty_flag), .empty_flag(empty_flag)
    );

    fifo_user_model #(.DATA_W(8)) fifo_user_model_inst (
        .clk_sys(clk_sys), .wr_clock(wr_clock), .wr_clock_enable(wr_clock_enable),
        .wr_request(wr_request), .wr_data(wr_data), .rd_clock(rd_clock),
        .rd_clock_enable(rd_clock_enable), .rd_request(rd_request)
    );

    task automatic ram_op(input bit b, input logic we, input logic [3:0] ad,
                          input logic [7:0] d, input wmode_e m, output logic [7:0] q);
        @(posedge clk_sys);
        if (b) begin
            port_b_ce <= 1'b1; port_b_we <= we; port_b_addr <= ad;
            port_b_wdata <= d; port_b_wmode <= m;
        end else begin
            port_a_ce <= 1'b1; port_a_we <= we; port_a_addr <= ad;
            port_a_wdata <= d; port_a_wmode <= m;
        end
        @(posedge clk_sys);
        port_a_ce <= 1'b0; port_a_we <= 1'b0; port_b_ce <= 1'b0; port_b_we <= 1'b0;
        #1 q = b ? port_b_rdata : port_a_rdata;
    endtask

    // Level resets by index; 3 selects the read pointer reset
    task automatic drive_rst(input int sel, input logic v);
        case (sel)
            0: port_a_latch_reset <= v;
            1: port_b_latch_reset <= v;
            2: global_reset_n <= v;
            default: read_pointer_reset_in <= v;
        endcase
    endtask

    // Pulse of one cycle on a level reset, settled one step after release edge
    task automatic pulse(input int sel, input logic act);
        @(posedge clk_sys);
        drive_rst(sel, act);
        @(posedge clk_sys);
        drive_rst(sel, ~act);
        #1;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        conclude();
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        #1;
        `CHK("full", 1'b0, full_flag)
        `CHK("near_full", 1'b0, near_full_flag)
        `CHK("near_empty", 1'b1, near_empty_flag)
        `CHK("empty", 1'b1, empty_flag)
        $display("test reset done");

        ram_op(0, 1'b1, 4'h3, 8'hA5, WM_NORMAL, got);
        `CHK("normal write", 8'h00, got)
        ram_op(0, 1'b0, 4'h3, 8'h00, WM_NORMAL, got);
        `CHK("normal read", 8'hA5, got)
        ram_op(0, 1'b1, 4'h3, 8'h3C, WM_THROUGH, got);
        `CHK("through", 8'h3C, got)
        ram_op(0, 1'b1, 4'h3, 8'hC3, WM_RBW, got);
        `CHK("rbw", 8'h3C, got)
        ram_op(1, 1'b1, 4'h3, 8'h5A, WM_RBW, got);
        `CHK("rbw b", 8'hC3, got)
        ram_op(1, 1'b0, 4'h3, 8'h00, WM_NORMAL, got);
        `CHK("read b", 8'h5A, got)
        $display("test ram modes done");

        pulse(0, 1'b1);
        `CHK("latch a", 8'h00, port_a_rdata)
        `CHK("latch b kept", 8'h5A, port_b_rdata)
        ram_op(0, 1'b0, 4'h3, 8'h00, WM_NORMAL, got);
        `CHK("read a", 8'h5A, got)
        pulse(1, 1'b1);
        `CHK("latch b", 8'h00, port_b_rdata)
        `CHK("latch a kept", 8'h5A, port_a_rdata)
        ram_op(1, 1'b0, 4'h3, 8'h00, WM_NORMAL, got);
        `CHK("read b again", 8'h5A, got)
        pulse(2, 1'b0);
        `CHK("global a", 8'h00, port_a_rdata)
        `CHK("global b", 8'h00, port_b_rdata)
        $display("test latch resets done");

        fifo_mode <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            fifo_user_model_inst.push(8'h10 + i[7:0], 1'b1);
            `CHK("near_full", logic'(i >= 2), near_full_flag)
            `CHK("full", logic'(i == 3), full_flag)
        end
        fifo_user_model_inst.push(8'hEE, 1'b1);
        `CHK("empty no rd tick", 1'b1, empty_flag)
        repeat (3) fifo_user_model_inst.pull(1'b0);
        `CHK("empty cleared", 1'b0, empty_flag)
        `CHK("near_empty", 1'b0, near_empty_flag)
        for (int i = 0; i < 4; i++) begin
            fifo_user_model_inst.pull(1'b1);
            `CHK("fifo data", 8'h10 + i[7:0], port_b_rdata)
            `CHK("near_empty", logic'(i >= 2), near_empty_flag)
            `CHK("empty", logic'(i == 3), empty_flag)
        end
        fifo_user_model_inst.pull(1'b1);
        `CHK("read when empty", 8'h13, port_b_rdata)
        $display("test fifo flow done");

        pulse(3, 1'b1);
        fifo_user_model_inst.pull(1'b0);
        `CHK("replay empty", 1'b0, empty_flag)
        for (int i = 0; i < 4; i++) begin
            fifo_user_model_inst.pull(1'b1);
            `CHK("replay data", 8'h10 + i[7:0], port_b_rdata)
        end
        $display("test replay done");

        // Write side needs three idle ticks before its flags see the replayed read pointer
        repeat (3) fifo_user_model_inst.push(8'h00, 1'b0);
        `CHK("full cleared", 1'b0, full_flag)
        `CHK("near_full cleared", 1'b0, near_full_flag)
        fifo_user_model_inst.push(8'h20, 1'b1);
        repeat (3) fifo_user_model_inst.pull(1'b0);
        `CHK("pre reset empty", 1'b0, empty_flag)
        @(posedge clk_sys);
        fifo_reset <= 1'b1;
        #1;
        `CHK("async empty", 1'b1, empty_flag)
        `CHK("async near_empty", 1'b1, near_empty_flag)
        `CHK("async full", 1'b0, full_flag)
        @(posedge clk_sys);
        fifo_reset <= 1'b0;
        repeat (3) fifo_user_model_inst.pull(1'b0);
        `CHK("cleared fifo", 1'b1, empty_flag)
        $display("test fifo reset done");

        @(posedge clk_sys);
        full_level <= 4'h2;
        near_full_level <= 4'h1;
        near_empty_level <= 4'h2;
        fifo_user_model_inst.push(8'h30, 1'b1);
        `CHK("low near_full", 1'b1, near_full_flag)
        `CHK("low full off", 1'b0, full_flag)
        fifo_user_model_inst.push(8'h31, 1'b1);
        `CHK("low full", 1'b1, full_flag)
        repeat (3) fifo_user_model_inst.pull(1'b0);
        `CHK("low near_empty", 1'b1, near_empty_flag)
        `CHK("low empty off", 1'b0, empty_flag)
        fifo_user_model_inst.pull(1'b1);
        `CHK("low data", 8'h30, port_b_rdata)
        $display("test levels done");
        conclude();
    end
endmodule

// ==== bench/fifo_user_model.sv ====
`timescale 1ns/1ns

module fifo_user_model #(
    parameter int DATA_W = 8
) (
    input wire logic clk_sys,
    output logic wr_clock,
    output logic wr_clock_enable,
    output logic wr_request,
    output logic [DATA_W-1:0] wr_data,
    output logic rd_clock,
    output logic rd_clock_enable,
    output logic rd_request
);
    initial begin
        wr_clock = 1'b0;
        wr_clock_enable = 1'b0;
        wr_request = 1'b0;
        wr_data = '0;
        rd_clock = 1'b0;
        rd_clock_enable = 1'b0;
        rd_request = 1'b0;
    end

    // One write tick; enables drop between ticks so resets may land anytime
    task automatic push(input logic [DATA_W-1:0] d, input logic req);
        @(posedge clk_sys);
        wr_clock <= 1'b0;
        @(posedge clk_sys);
        wr_clock <= 1'b1;
        wr_clock_enable <= 1'b1;
        wr_request <= req;
        wr_data <= d;
        @(posedge clk_sys);
        wr_clock <= 1'b0;
        wr_clock_enable <= 1'b0;
        wr_request <= 1'b0;
        // Stale data must not look valid after the tick
        wr_data <= ~d;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic pull(input logic req);
        @(posedge clk_sys);
        rd_clock <= 1'b0;
        @(posedge clk_sys);
        rd_clock <= 1'b1;
        rd_clock_enable <= 1'b1;
        rd_request <= req;
        @(posedge clk_sys);
        rd_clock <= 1'b0;
        rd_clock_enable <= 1'b0;
        rd_request <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
endmodule

// ==== shared/brf_pkg.sv ====
`include "brf_regs.svh"

package brf_pkg;

    typedef enum logic [1:0] {
        WM_NORMAL = `BRF_WM_NORMAL,
        WM_THROUGH = `BRF_WM_THROUGH,
        WM_RBW = `BRF_WM_RBW
    } wmode_e;

endpackage

// ==== shared/brf_regs.svh ====
`ifndef BRF_REGS_SVH
`define BRF_REGS_SVH

// Write behaviour select codes
`define BRF_WM_NORMAL 2'h0
`define BRF_WM_THROUGH 2'h1
`define BRF_WM_RBW 2'h2

// Pointer advance per accepted access
`define BRF_PTR_STEP 1'h1

// Flag values after a FIFO full reset
`define BRF_FULL_RST 1'h0
`define BRF_NEAR_FULL_RST 1'h0
`define BRF_NEAR_EMPTY_RST 1'h1
`define BRF_EMPTY_RST 1'h1

`endif

// ==== shared/ptr_sync_if.sv ====
`timescale 1ns/1ns

interface ptr_sync_if #(
    parameter int W = 5
);
    logic tick;
    logic [W-1:0] gray_in;
    logic [W-1:0] gray_out;

    modport sync (
        input tick,
        input gray_in,
        output gray_out
    );

    modport user (
        output tick,
        output gray_in,
        input gray_out
    );
endinterface

// ==== src/block_ram_fifo_and_ports.sv ====
`timescale 1ns/1ns
`include "brf_regs.svh"
// Function
// - Normal write: output changes only on reads, writes leave it unchanged.
// - Write-through: output shows the data written on the same port.
// - Read-before-write: output shows the old contents of the written word.
// - FIFO write side and read side each with data, clock enable, request, clock.
// - Full, near full, near empty and empty flags are generated inside.
// - Full and near full are flops updated on write clock ticks.
// - Empty and near empty are flops updated on read clock ticks.
// - Programmable full, near full, near empty levels; empty level is zero.
// - FIFO reset clears both pointers and returns all flags to reset values.
// - Read pointer reset clears only the read pointer for replay.
// - Each port has output latches with sync or async reset by configuration.
// - Separate local resets clear the port A and port B latches only.
// - Active low global reset clears both port latches together.
// - FIFO reset and read pointer reset act asynchronously.
module block_ram_fifo_and_ports
    import brf_pkg::*;
#(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 8,
    parameter bit LATCH_ASYNC_RST = 1'b0
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic global_reset_n,
    input wire logic port_a_latch_reset,
    input wire logic port_b_latch_reset,
    input wire logic fifo_mode,
    input wire logic [ADDR_W-1:0] port_a_addr,
    input wire logic [DATA_W-1:0] port_a_wdata,
    input wire logic port_a_ce,
    input wire logic port_a_we,
    input wmode_e port_a_wmode,
    input wire logic [ADDR_W-1:0] port_b_addr,
    input wire logic [DATA_W-1:0] port_b_wdata,
    input wire logic port_b_ce,
    input wire logic port_b_we,
    input wmode_e port_b_wmode,
    input wire logic wr_clock,
    input wire logic wr_clock_enable,
    input wire logic wr_request,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic rd_clock,
    input wire logic rd_clock_enable,
    input wire logic rd_request,
    input wire logic fifo_reset,
    input wire logic read_pointer_reset_in,
    input wire logic [ADDR_W-1:0] full_level,
    input wire logic [ADDR_W-1:0] near_full_level,
    input wire logic [ADDR_W-1:0] near_empty_level,
    output logic [DATA_W-1:0] port_a_rdata,
    output logic [DATA_W-1:0] port_b_rdata,
    output logic full_flag,
    output logic near_full_flag,
    output logic near_empty_flag,
    output logic empty_flag
);
    localparam int DEPTH = 1 << ADDR_W;

    typedef logic [ADDR_W:0] ptr_t;

    function automatic ptr_t bin2gray(input ptr_t b);
        return b ^ (b >> 1);
    endfunction

    function automatic ptr_t gray2bin(input ptr_t g);
        ptr_t b;
        b = g;
        for (int k = ADDR_W - 1; k >= 0; k--) begin
            b[k] = b[k+1] ^ g[k];
        end
        return b;
    endfunction

    // Side clocks arrive as levels; a rising edge is one tick of that side
    logic wr_clk_q_ff;
    logic rd_clk_q_ff;
    logic nxt_wr_clk_q;
    logic nxt_rd_clk_q;
    logic wr_tick;
    logic rd_tick;

    always_comb begin
        nxt_wr_clk_q = wr_clock;
        nxt_rd_clk_q = rd_clock;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_clk_q_ff <= 1'b0;
            rd_clk_q_ff <= 1'b0;
        end else begin
            wr_clk_q_ff <= nxt_wr_clk_q;
            rd_clk_q_ff <= nxt_rd_clk_q;
        end
    end

    assign wr_tick = wr_clock & ~wr_clk_q_ff;
    assign rd_tick = rd_clock & ~rd_clk_q_ff;

    // Resets of the FIFO pointers act without waiting for a tick
    logic fifo_rst_n;
    logic rd_rst_n;
    assign fifo_rst_n = arst_n & ~fifo_reset;
    assign rd_rst_n = fifo_rst_n & ~read_pointer_reset_in;

    logic full_ff;
    logic near_full_ff;
    logic near_empty_ff;
    logic empty_ff;
    logic wr_go;
    logic rd_go;

    // Requests against a full or empty FIFO are dropped here
    assign wr_go = fifo_mode & wr_tick & wr_clock_enable & wr_request & ~full_ff;
    assign rd_go = fifo_mode & rd_tick & rd_clock_enable & rd_request & ~empty_ff;

    ptr_t wr_ptr_ff;
    ptr_t rd_ptr_ff;
    ptr_t nxt_wr_ptr;
    ptr_t nxt_rd_ptr;

    always_comb begin
        nxt_wr_ptr = wr_go ? wr_ptr_ff + ptr_t'(`BRF_PTR_STEP) : wr_ptr_ff;
        nxt_rd_ptr = rd_go ? rd_ptr_ff + ptr_t'(`BRF_PTR_STEP) : rd_ptr_ff;
    end

    always_ff @(posedge clk_sys or negedge fifo_rst_n) begin
        if (!fifo_rst_n) begin
            wr_ptr_ff <= '0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
        end
    end

    // Replay: only the read pointer returns to the start
    always_ff @(posedge clk_sys or negedge rd_rst_n) begin
        if (!rd_rst_n) begin
            rd_ptr_ff <= '0;
        end else begin
            rd_ptr_ff <= nxt_rd_ptr;
        end
    end

    // Gray pointers cross into the other side, stepped by that side's ticks
    ptr_sync_if #(.W(ADDR_W + 1)) rd2wr_if ();
    ptr_sync_if #(.W(ADDR_W + 1)) wr2rd_if ();

    assign rd2wr_if.tick = wr_tick;
    assign rd2wr_if.gray_in = bin2gray(rd_ptr_ff);
    assign wr2rd_if.tick = rd_tick;
    assign wr2rd_if.gray_in = bin2gray(wr_ptr_ff);

    ptr_sync u_rd2wr (
        .clk_sys(clk_sys),
        .rst_n(rd_rst_n),
        .port(rd2wr_if.sync)
    );

    ptr_sync u_wr2rd (
        .clk_sys(clk_sys),
        .rst_n(fifo_rst_n),
        .port(wr2rd_if.sync)
    );

    // Stale far pointer only overstates fullness or emptiness, never the reverse
    ptr_t wr_occ;
    ptr_t rd_occ;
    logic nxt_full;
    logic nxt_near_full;
    logic nxt_near_empty;
    logic nxt_empty;

    always_comb begin
        wr_occ = nxt_wr_ptr - gray2bin(rd2wr_if.gray_out);
        rd_occ = gray2bin(wr2rd_if.gray_out) - nxt_rd_ptr;
        nxt_full = full_ff;
        nxt_near_full = near_full_ff;
        nxt_near_empty = near_empty_ff;
        nxt_empty = empty_ff;
        if (wr_tick) begin
            nxt_full = wr_occ >= ptr_t'(full_level);
            nxt_near_full = wr_occ >= ptr_t'(near_full_level);
        end
        if (rd_tick) begin
            nxt_near_empty = rd_occ <= ptr_t'(near_empty_level);
            nxt_empty = rd_occ == '0;
        end
    end

    always_ff @(posedge clk_sys or negedge fifo_rst_n) begin
        if (!fifo_rst_n) begin
            full_ff <= `BRF_FULL_RST;
            near_full_ff <= `BRF_NEAR_FULL_RST;
            near_empty_ff <= `BRF_NEAR_EMPTY_RST;
            empty_ff <= `BRF_EMPTY_RST;
        end else begin
            full_ff <= nxt_full;
            near_full_ff <= nxt_near_full;
            near_empty_ff <= nxt_near_empty;
            empty_ff <= nxt_empty;
        end
    end

    assign full_flag = full_ff;
    assign near_full_flag = near_full_ff;
    assign near_empty_flag = near_empty_ff;
    assign empty_flag = empty_ff;

    // In FIFO use port A is the write side and port B the read side
    logic [1:0] p_ce;
    logic [1:0] p_we;
    logic [1:0] p_lrst;
    logic [ADDR_W-1:0] p_addr [2];
    logic [DATA_W-1:0] p_wd [2];
    wmode_e p_mode [2];

    always_comb begin
        p_lrst = {port_b_latch_reset, port_a_latch_reset};
        if (fifo_mode) begin
            p_ce = {rd_go, wr_go};
            p_we = 2'h1;
            p_addr[0] = wr_ptr_ff[ADDR_W-1:0];
            p_addr[1] = rd_ptr_ff[ADDR_W-1:0];
            p_wd[0] = wr_data;
            p_wd[1] = port_b_wdata;
            p_mode[0] = WM_NORMAL;
            p_mode[1] = WM_NORMAL;
        end else begin
            p_ce = {port_b_ce, port_a_ce};
            p_we = {port_b_we, port_a_we};
            p_addr[0] = port_a_addr;
            p_addr[1] = port_b_addr;
            p_wd[0] = port_a_wdata;
            p_wd[1] = port_b_wdata;
            p_mode[0] = port_a_wmode;
            p_mode[1] = port_b_wmode;
        end
    end

    logic [DATA_W-1:0] mem_ff [DEPTH];
    logic [DATA_W-1:0] nxt_mem [DEPTH];

    // Same address written by both ports: port A wins, applied last
    always_comb begin
        nxt_mem = mem_ff;
        for (int i = 1; i >= 0; i--) begin
            if (p_ce[i] && p_we[i]) begin
                nxt_mem[p_addr[i]] = p_wd[i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        mem_ff <= nxt_mem;
    end

    // Unpacked so each generate branch owns its own element
    logic [DATA_W-1:0] q_ff [2];

    for (genvar i = 0; i < 2; i++) begin : g_port
        logic [DATA_W-1:0] nxt_q;
        logic lrst_n;

        assign lrst_n = arst_n & global_reset_n & ~p_lrst[i];

        always_comb begin
            nxt_q = q_ff[i];
            if (p_ce[i]) begin
                if (!p_we[i]) begin
                    nxt_q = mem_ff[p_addr[i]];
                end else begin
                    unique case (p_mode[i])
                        WM_NORMAL: nxt_q = q_ff[i];
                        WM_THROUGH: nxt_q = p_wd[i];
                        WM_RBW: nxt_q = mem_ff[p_addr[i]];
                        default: nxt_q = q_ff[i];
                    endcase
                end
            end
            if (!LATCH_ASYNC_RST && !lrst_n) begin
                nxt_q = '0;
            end
        end

        if (LATCH_ASYNC_RST) begin : g_async
            always_ff @(posedge clk_sys or negedge lrst_n) begin
                if (!lrst_n) begin
                    q_ff[i] <= '0;
                end else begin
                    q_ff[i] <= nxt_q;
                end
            end
        end else begin : g_sync
            always_ff @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    q_ff[i] <= '0;
                end else begin
                    q_ff[i] <= nxt_q;
                end
            end
        end
    end

    assign port_a_rdata = q_ff[0];
    assign port_b_rdata = q_ff[1];

    logic [DATA_W-1:0] old_a;
    assign old_a = mem_ff[port_a_addr];

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    sequence s_wr_req;
        fifo_mode && wr_tick && wr_clock_enable && wr_request && !fifo_reset;
    endsequence

    sequence s_rd_req;
        fifo_mode && rd_tick && rd_clock_enable && rd_request && !fifo_reset
            && !read_pointer_reset_in;
    endsequence

    // A latch reset in the write cycle itself wins over the write behaviour
    sequence s_a_write(wmode_e m);
        !fifo_mode && port_a_ce && port_a_we && port_a_wmode == m
            && global_reset_n && !port_a_latch_reset;
    endsequence

    AST_FULL_DROP: assert property ((s_wr_req ##0 full_ff) |=>
        (fifo_reset || $stable(wr_ptr_ff))) else $error("write taken while full");
    AST_EMPTY_DROP: assert property ((s_rd_req ##0 empty_ff) |=>
        (fifo_reset || read_pointer_reset_in || $stable(rd_ptr_ff)))
        else $error("read taken while empty");
    AST_WRITE_STEP: assert property ((s_wr_req ##0 !full_ff) |=>
        (fifo_reset || wr_ptr_ff == ptr_t'($past(wr_ptr_ff) + ptr_t'(`BRF_PTR_STEP))))
        else $error("accepted write did not advance pointer");
    AST_WT_COPY: assert property (s_a_write(WM_THROUGH) |=>
        (!global_reset_n || port_a_latch_reset || port_a_rdata == $past(port_a_wdata)))
        else $error("write-through output wrong");
    AST_NORMAL_HOLD: assert property (s_a_write(WM_NORMAL) |=>
        (!global_reset_n || port_a_latch_reset || $stable(port_a_rdata)))
        else $error("normal write changed output");
    AST_RBW_OLD: assert property (s_a_write(WM_RBW) |=>
        (!global_reset_n || port_a_latch_reset || port_a_rdata == $past(old_a)))
        else $error("read-before-write output wrong");
    AST_A_LATCH_RST: assert property (port_a_latch_reset && global_reset_n
        && !port_b_latch_reset && !p_ce[1] |=> port_a_rdata == '0 && $stable(port_b_rdata))
        else $error("port A latch reset wrong");
    AST_GLOBAL_RST: assert property (!global_reset_n |=>
        port_a_rdata == '0 && port_b_rdata == '0) else $error("global reset missed a port");
    AST_RP_RST: assert property (read_pointer_reset_in && !fifo_reset && !wr_go |=>
        rd_ptr_ff == '0 && $stable(wr_ptr_ff)) else $error("read pointer reset wrong");
    AST_FIFO_RST: assert property (fifo_reset |=> wr_ptr_ff == '0 && rd_ptr_ff == '0
        && empty_ff && near_empty_ff && !full_ff && !near_full_ff)
        else $error("fifo reset incomplete");
    AST_WR_FLAGS_HOLD: assert property (!wr_tick && !fifo_reset |=>
        (fifo_reset || ($stable(full_ff) && $stable(near_full_ff))))
        else $error("write flags moved without write tick");
    AST_RD_FLAGS_HOLD: assert property (!rd_tick && !fifo_reset |=>
        (fifo_reset || ($stable(empty_ff) && $stable(near_empty_ff))))
        else $error("read flags moved without read tick");
    AST_EMPTY_NEAR: assert property (empty_ff |-> near_empty_ff)
        else $error("empty without near empty");
endmodule

// ==== src/ptr_sync.sv ====
`timescale 1ns/1ns

module ptr_sync (
    input wire logic clk_sys,
    input wire logic rst_n,
    ptr_sync_if.sync port
);
    localparam int W = $bits(port.gray_in);

    logic [W-1:0] meta_ff;
    logic [W-1:0] hold_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_hold;

    // Two stages, both stepped by the destination side tick
    always_comb begin
        nxt_meta = port.tick ? port.gray_in : meta_ff;
        nxt_hold = port.tick ? meta_ff : hold_ff;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            hold_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            hold_ff <= nxt_hold;
        end
    end

    assign port.gray_out = hold_ff;
endmodule
